// ### core/mclr_config_lock.sv
// What this block does
// [R1] Run enabled: use programmed limits
// [R2] Run off: defaults, keep programmed limits
// [R3] Lock freezes the run enable bit
// [R4] Software programs limits before run
// [R5] Lock is write-once until power cycle
// [R6] Writes to locked fields silently ignored
// [R7] Ready flag set after power-up
// [R8] Override bit forces fans full speed
// [R9] Override bit never locked
// [R10] Spin-up mode holds drive whole timeout
// [R11] Timeout-off bit disables bus timeout
// [R12] Supply scale: 1 is 5V, 0 is 3.3V
// [R13] Format bit: 0 binary, 1 offset
// [R14] Power-on value is 0x01
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mclr_config_lock
  import mclr_pkg::*;
#(
  parameter int POWERUP_CYC = POWERUP_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Block controls
  output logic             useProgrammedLimits,
  output logic             limitsLocked,
  output logic             deviceReady,
  output logic             fan_full_override,
  output logic             spinup_pulse_mode_off,
  output logic             bus_timeout_off,
  output logic             supplyScale5v,
  output logic             temp_offset_format
);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire accessPhase = psel & penable;
  wire wrEn        = accessPhase & pwrite & pstrb[0];
  wire selCfg      = (paddr == ADDR_PRIMARY_CFG);
  wire selT2       = (paddr == ADDR_TEST_TWO);
  wire selT3       = (paddr == ADDR_TEST_THREE);
  wire selT4       = (paddr == ADDR_TEST_FOUR);
  wire selStat     = (paddr == ADDR_STATUS);
  wire mapped      = selCfg | selT2 | selT3 | selT4 | selStat;

  assign pready  = 1'b1;
  assign pslverr = accessPhase & ~mapped;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] cfgFf;
  logic [7:0] nxt_cfgFf;
  logic [7:0] testFf [NUM_TEST_REGS];
  logic [7:0] rdataMux;
  logic [31:0] prdataFf;
  logic       readyFlag;
  wire  [7:0] wByte  = pwdata[7:0];
  wire        lockOn = cfgFf[BIT_LOCK];

  mclr_powerup_timer #(
    .CYCLES (POWERUP_CYC)
  ) uPowerup (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .readyFlag (readyFlag)
  );

  // Next value of the primary configuration register
  always_comb begin
    nxt_cfgFf = cfgFf;
    if (wrEn && selCfg) begin
      // [R9] override always writable
      nxt_cfgFf[BIT_FAN_FULL] = wByte[BIT_FAN_FULL];
      // [R6] locked writes ignored
      if (!lockOn) begin
        // [R3] run bit frozen by lock
        nxt_cfgFf[BIT_RUN_ENABLE]    = wByte[BIT_RUN_ENABLE];
        nxt_cfgFf[BIT_SPINUP_MODE]   = wByte[BIT_SPINUP_MODE];
        nxt_cfgFf[BIT_TIMEOUT_OFF]   = wByte[BIT_TIMEOUT_OFF];
        nxt_cfgFf[BIT_SUPPLY_SCALE]  = wByte[BIT_SUPPLY_SCALE];
        nxt_cfgFf[BIT_OFFSET_FORMAT] = wByte[BIT_OFFSET_FORMAT];
        // [R5] write-once lock
        nxt_cfgFf[BIT_LOCK]          = wByte[BIT_LOCK];
      end
    end
    // Ready is hardware owned, never stored from the bus
    nxt_cfgFf[BIT_READY] = 1'b0;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // [R14] power-on value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfgFf <= RST_PRIMARY_CFG;
    end else begin
      cfgFf <= nxt_cfgFf;
    end
  end

  // Test registers are lockable like the limits
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TEST_REGS; gi++) begin : gTest
      wire hit = (gi == 0) ? selT2 : ((gi == 1) ? selT3 : selT4);
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          testFf[gi] <= RST_TEST;
        // [R6] locked test regs
        end else if (wrEn && hit && !lockOn) begin
          testFf[gi] <= wByte;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // [R7] ready flag readback
  assign rdataMux = selCfg  ? {cfgFf[7:3], readyFlag, cfgFf[1:0]} :
                    selT2   ? testFf[0] :
                    selT3   ? testFf[1] :
                    selT4   ? testFf[2] :
                    selStat ? {6'h00, readyFlag, lockOn} : 8'h00;

  // Read data is registered in the setup cycle, valid in access
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdataFf <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdataFf <= {24'h000000, rdataMux};
    end
  end
  assign prdata = prdataFf;

  // ---------------------------------------------------------------
  // Block controls
  // ---------------------------------------------------------------
  // [R1] programmed limits when running
  // [R2] defaults otherwise, limits kept
  assign useProgrammedLimits   = cfgFf[BIT_RUN_ENABLE];
  assign limitsLocked          = lockOn;
  assign deviceReady           = readyFlag;
  // [R8] fans full speed
  assign fan_full_override     = cfgFf[BIT_FAN_FULL];
  // [R10] spin-up held for timeout
  assign spinup_pulse_mode_off = cfgFf[BIT_SPINUP_MODE];
  // [R11] bus timeout disable
  assign bus_timeout_off       = cfgFf[BIT_TIMEOUT_OFF];
  // [R12] supply scaling
  assign supplyScale5v         = cfgFf[BIT_SUPPLY_SCALE];
  // [R13] temperature format
  assign temp_offset_format    = cfgFf[BIT_OFFSET_FORMAT];
endmodule
`default_nettype wire

// ### core/mclr_pkg.sv
package mclr_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_PRIMARY_CFG = 12'h000;
  localparam logic [11:0] ADDR_TEST_TWO    = 12'h004;
  localparam logic [11:0] ADDR_TEST_THREE  = 12'h008;
  localparam logic [11:0] ADDR_TEST_FOUR   = 12'h00c;
  localparam logic [11:0] ADDR_STATUS      = 12'h010;
  // ---------------------------------------------------------------
  // Primary configuration fields
  // ---------------------------------------------------------------
  localparam int BIT_RUN_ENABLE    = 0;
  localparam int BIT_LOCK          = 1;
  localparam int BIT_READY         = 2;
  localparam int BIT_FAN_FULL      = 3;
  localparam int BIT_SPINUP_MODE   = 4;
  localparam int BIT_TIMEOUT_OFF   = 5;
  localparam int BIT_SUPPLY_SCALE  = 6;
  localparam int BIT_OFFSET_FORMAT = 7;
  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PRIMARY_CFG = 8'h01;
  localparam logic [7:0] RST_TEST        = 8'h00;
  localparam int         CLK_FREQ_HZ     = 40000000;
  localparam int         POWERUP_TIME_US = 10;
  localparam int         POWERUP_CYCLES  = (POWERUP_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int         NUM_TEST_REGS   = 3;
endpackage

// ### core/mclr_powerup_timer.sv
`timescale 1ns/100ps
`default_nettype none
module mclr_powerup_timer
  import mclr_pkg::*;
#(
  parameter int CYCLES = POWERUP_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Status
  output var  logic readyFlag
);
  logic [15:0] countFf;
  logic        readyFf;
  wire         countDone = (countFf == 16'(CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      countFf <= 16'h0000;
      readyFf <= 1'b0;
    end else if (!readyFf) begin
      countFf <= countFf + 16'h0001;
      readyFf <= countDone;
    end
  end

  assign readyFlag = readyFf;
endmodule
`default_nettype wire

// ### verification/mclr_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module mclr_assertions
  import mclr_pkg::*;
(
  // Watched ports
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        useProgrammedLimits,
  input wire logic        limitsLocked,
  input wire logic        deviceReady,
  input wire logic        fan_full_override,
  input wire logic        bus_timeout_off
);
  // Bench always drives lane 0, so the strobe is left out here
  wire cfgWr = psel && penable && pwrite && (paddr == ADDR_PRIMARY_CFG);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  lock_sticky_a: assert property (limitsLocked |=> limitsLocked)
    else $error("lock bit cleared");
  lock_set_a: assert property (!limitsLocked && cfgWr && pwdata[1] |=> limitsLocked)
    else $error("lock bit not set");
  run_write_a: assert property (!limitsLocked && cfgWr |=> useProgrammedLimits == $past(pwdata[0]))
    else $error("run enable not written");
  run_frozen_a: assert property (limitsLocked && cfgWr |=> $stable(useProgrammedLimits))
    else $error("run enable changed while locked");
  fan_free_a: assert property (cfgWr |=> fan_full_override == $past(pwdata[3]))
    else $error("override bit not written");
  timeout_frozen_a: assert property (limitsLocked && cfgWr |=> $stable(bus_timeout_off))
    else $error("timeout bit changed while locked");
  ready_hold_a: assert property (deviceReady |=> deviceReady)
    else $error("ready flag dropped");
  power_on_a: assert property (!$past(rst_n) |-> useProgrammedLimits && !limitsLocked
    && !fan_full_override && !deviceReady) else $error("wrong value after reset");
endmodule
bind mclr_config_lock mclr_assertions chk_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .useProgrammedLimits(useProgrammedLimits), .limitsLocked(limitsLocked),
  .deviceReady(deviceReady), .fan_full_override(fan_full_override),
  .bus_timeout_off(bus_timeout_off));
`default_nettype wire

// ### verification/monitor_config_lock_register_tb.sv
`timescale 1ns/100ps
`default_nettype none
module monitor_config_lock_register_tb;
  import mclr_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire  [7:0]  outs;
  logic [31:0] seed = 32'h131026bf;
  logic [7:0]  cfg;
  logic [7:0]  tr[3] = '{default: RST_TEST};
  int          n_mismatch = 0;
  int          checks = 0;
  always #12.5 core_clk = ~core_clk;
  mclr_config_lock #(.POWERUP_CYC(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .useProgrammedLimits(outs[0]),
    .limitsLocked(outs[1]), .deviceReady(outs[2]), .fan_full_override(outs[3]),
    .spinup_pulse_mode_off(outs[4]), .bus_timeout_off(outs[5]), .supplyScale5v(outs[6]),
    .temp_offset_format(outs[7]));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Locked: only the override bit moves; ready is up by then
  function automatic logic [7:0] nxtCfg(input logic [7:0] c, input logic [7:0] w);
    return c[1] ? {c[7:4], w[3], c[2:0]} : {w[7:3], 1'b1, w[1:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ap(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    chk(pslverr, a > ADDR_STATUS);
    if (!w) chk(prdata, {24'h0, d});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    cfg = RST_PRIMARY_CFG;
    ap(1'b0, ADDR_PRIMARY_CFG, cfg);
    repeat (6) @(posedge core_clk);
    cfg = nxtCfg(cfg, 8'h00);
    ap(1'b1, ADDR_PRIMARY_CFG, 8'h00);
    ap(1'b0, ADDR_PRIMARY_CFG, cfg);
    for (int j = 0; j < 3; j++) begin
      seed = xs(seed);
      tr[j] = seed[7:0];
      ap(1'b1, ADDR_TEST_TWO + 12'(4 * j), seed[7:0]);
      ap(1'b0, ADDR_TEST_TWO + 12'(4 * j), tr[j]);
    end
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      seed[1] = (i == 12) | ((i > 12) & seed[1]);
      cfg = nxtCfg(cfg, seed[7:0]);
      if (!cfg[1]) tr[i % 3] = seed[15:8];
      ap(1'b1, ADDR_PRIMARY_CFG, seed[7:0]);
      ap(1'b0, ADDR_PRIMARY_CFG, cfg);
      chk(outs, cfg);
      ap(1'b1, ADDR_TEST_TWO + 12'(4 * (i % 3)), seed[15:8]);
      ap(1'b0, ADDR_TEST_TWO + 12'(4 * (i % 3)), tr[i % 3]);
    end
    ap(1'b0, ADDR_STATUS, 8'h03);
    ap(1'b1, 12'h014, 8'hff);
    ap(1'b0, 12'h014, 8'h00);
    ap(1'b0, ADDR_PRIMARY_CFG, cfg);
    test_done();
  end
endmodule
`default_nettype wire
